// [dtc_pkg.sv]
// Purpose: Shared constants for the termination control block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   Mode register images hold the low 16 address bits of a mode register set
package dtc_pkg;

  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 32;
  localparam int          MR_W          = 16;
  localparam int          LAT_W         = 5;
  localparam int          FLD_W         = 3;

  // Register byte offsets
  localparam logic [4:0]  OFS_MODE_ZERO = 5'h00;
  localparam logic [4:0]  OFS_MODE_ONE  = 5'h04;
  localparam logic [4:0]  OFS_MODE_TWO  = 5'h08;
  localparam logic [4:0]  OFS_CONTROL   = 5'h0c;
  localparam logic [4:0]  OFS_STATUS    = 5'h10;

  // Reset values
  localparam logic [15:0] MR_RESET      = 16'h0000;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;

  // Control register bits
  localparam int          CTRL_W        = 3;
  localparam int          CTRL_SELF_REF = 0;
  localparam int          CTRL_PDOWN    = 1;
  localparam int          CTRL_DLL_LOCK = 2;

  // Status register bits
  localparam int          ST_TERM_ON    = 0;
  localparam int          ST_WR_STR     = 1;
  localparam int          ST_DYN_EN     = 2;
  localparam int          ST_ASYNC      = 3;
  localparam int          ST_CODE_LSB   = 4;

  // Mode register field positions
  localparam int          MR0_BL_LSB    = 0;
  localparam int          MR0_CL_HI     = 2;
  localparam int          MR0_CL_LSB    = 4;
  localparam int          MR0_DLL_KEEP  = 12;
  localparam int          MR1_DLL_OFF   = 0;
  localparam int          MR1_NOM_B0    = 2;
  localparam int          MR1_AL_LSB    = 3;
  localparam int          MR1_NOM_B1    = 6;
  localparam int          MR1_NOM_B2    = 9;
  localparam int          MR2_CWL_LSB   = 3;
  localparam int          MR2_WR_LSB    = 9;

  // Burst length field codes
  localparam logic [1:0]  BL_FIXED_FULL = 2'h0;
  localparam logic [1:0]  BL_OTF        = 2'h1;
  localparam logic [1:0]  BL_FIXED_CHOP = 2'h2;

  // Additive latency field codes
  localparam logic [1:0]  AL_ZERO       = 2'h0;
  localparam logic [1:0]  AL_CL_MINUS1  = 2'h1;
  localparam logic [1:0]  AL_CL_MINUS2  = 2'h2;

  // Latency arithmetic
  localparam logic [4:0]  CWL_BASE      = 5'h05;
  localparam logic [4:0]  CL_BASE       = 5'h04;
  localparam logic [4:0]  WL_TERM_SUB   = 5'h02;
  localparam logic [4:0]  ONE_CYCLE     = 5'h01;
  localparam logic [4:0]  LAT_MIN       = 5'h03;

  // Strength hold after a write, added to the on latency
  localparam logic [2:0]  HOLD_CHOP     = 3'h4;
  localparam logic [2:0]  HOLD_FULL     = 3'h6;
  localparam logic [2:0]  HOLD_LAST     = 3'h1;

  // Delay line lanes
  localparam int          DLY_W         = 3;
  localparam int          LANE_PIN      = 0;
  localparam int          LANE_WRITE    = 1;
  localparam int          LANE_CHOP     = 2;

endpackage

// [dtc_dly_if.sv]
// Purpose: Carrier between the control logic and its delay line
// Assumes: Tap index counts cycles of delay minus one
// Notes:   Output is a combinational read of the selected stage
interface dtc_dly_if #(
  parameter int W  = 3,
  parameter int AW = 5
);
  logic [W-1:0]  din;
  logic [AW-1:0] tap;
  logic [W-1:0]  dout;

  modport user (output din, output tap, input dout);
  modport line (input din, input tap, output dout);
endinterface

// [dtc_delay_line.sv]
// Purpose: Tapped shift register delaying the sampled pin and write events
// Assumes: Tap below DEPTH
// Notes:   Stage j holds the input sampled j+1 edges earlier
module dtc_delay_line #(
  parameter int W     = 3,
  parameter int DEPTH = 32
) (
  input  wire logic clock,
  input  wire logic rst_n,
  dtc_dly_if.line   dly
);
  logic [W-1:0] stage      [DEPTH];
  logic [W-1:0] next_stage [DEPTH];

  always_comb begin
    next_stage[0] = dly.din;
    for (int i = 1; i < DEPTH; i++) begin
      next_stage[i] = stage[i-1];
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rst_n) begin
        stage[i] <= '0;
      end else begin
        stage[i] <= next_stage[i];
      end
    end
  end

  assign dly.dout = stage[dly.tap];
endmodule

// [dtc_termination_ctrl.sv]
// Purpose: Termination on/off and strength control for data, strobe and mask lines
// Assumes: Pins and write commands are synchronous to clock; registers over Avalon-MM
// Notes:   Mode register images are loaded by software in place of a command decoder
module dtc_termination_ctrl
  import dtc_pkg::*;
#(
  parameter int DQ_WIDTH      = 16,
  parameter int STROBE_GROUPS = 2,
  parameter int DEPTH         = 32
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [ADDR_W-1:0]        avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [DATA_W-1:0]        avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [DATA_W-1:0]        avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     termination_control_pin,
  input  wire logic                     cmd_write,
  input  wire logic                     cmd_burst_full,
  output logic      [DQ_WIDTH-1:0]      term_dq,
  output logic      [STROBE_GROUPS-1:0] term_dqs,
  output logic      [STROBE_GROUPS-1:0] term_dqs_n,
  output logic      [STROBE_GROUPS-1:0] data_mask_term,
  output logic                          term_write_strength,
  output logic      [FLD_W-1:0]         term_code
);

  logic [MR_W-1:0]    mode_register_zero;
  logic [MR_W-1:0]    mode_register_one;
  logic [MR_W-1:0]    mode_register_two;
  logic [CTRL_W-1:0]  ctrl;
  logic [MR_W-1:0]    next_mr0;
  logic [MR_W-1:0]    next_mr1;
  logic [MR_W-1:0]    next_mr2;
  logic [CTRL_W-1:0]  next_ctrl;
  logic [DATA_W-1:0]  next_readdata;
  logic               next_waitrequest;

  logic               term_on;
  logic               next_term_on;
  logic               next_strength;
  logic [2:0]         hold_cnt;
  logic [2:0]         next_hold;
  logic [FLD_W-1:0]   next_code;

  logic [FLD_W-1:0]   nom_value;
  logic [1:0]         wr_value;
  logic               term_enabled;
  logic               dyn_en;
  logic               self_ref;
  logic               async_mode;
  logic               write_is_chop;
  logic [LAT_W-1:0]   write_cas_latency;
  logic [LAT_W-1:0]   cas_latency;
  logic [LAT_W-1:0]   additive_latency;
  logic [LAT_W-1:0]   term_on_latency;
  logic               write_arrive;

  dtc_dly_if #(.W(DLY_W), .AW(LAT_W)) dly ();

  dtc_delay_line #(.W(DLY_W), .DEPTH(DEPTH)) u_delay (
    .clock (clock),
    .rst_n (rst_n),
    .dly   (dly)
  );

  function automatic logic [MR_W-1:0] merge(input logic [MR_W-1:0]   old,
                                            input logic [DATA_W-1:0] wd,
                                            input logic [3:0]        be);
    logic [MR_W-1:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Mode register field decode
  assign nom_value = {mode_register_one[MR1_NOM_B2], mode_register_one[MR1_NOM_B1],
                      mode_register_one[MR1_NOM_B0]};
  assign wr_value = mode_register_two[MR2_WR_LSB+1:MR2_WR_LSB];
  assign term_enabled = (nom_value != '0) || (wr_value != '0);
  assign dyn_en = (wr_value != '0);
  assign self_ref = ctrl[CTRL_SELF_REF];
  // Precharge power-down with the DLL frozen; otherwise synchronous timing
  assign async_mode = ctrl[CTRL_PDOWN] && !mode_register_zero[MR0_DLL_KEEP];

  assign write_cas_latency = CWL_BASE + LAT_W'(mode_register_two[MR2_CWL_LSB+2:MR2_CWL_LSB]);
  assign cas_latency = CL_BASE + LAT_W'({mode_register_zero[MR0_CL_HI],
                                         mode_register_zero[MR0_CL_LSB+2:MR0_CL_LSB]});

  always_comb begin
    unique case (mode_register_one[MR1_AL_LSB+1:MR1_AL_LSB])
      AL_CL_MINUS1: additive_latency = cas_latency - ONE_CYCLE;
      AL_CL_MINUS2: additive_latency = cas_latency - WL_TERM_SUB;
      default:      additive_latency = '0;
    endcase
  end

  assign term_on_latency = write_cas_latency + additive_latency - WL_TERM_SUB;

  always_comb begin
    unique case (mode_register_zero[MR0_BL_LSB+1:MR0_BL_LSB])
      BL_OTF:        write_is_chop = !cmd_burst_full;
      BL_FIXED_CHOP: write_is_chop = 1'b1;
      default:       write_is_chop = 1'b0;
    endcase
  end

  // Pin and write events enter the delay line; tap gives the posted latency
  assign dly.din[LANE_PIN]   = termination_control_pin && !self_ref;
  assign dly.din[LANE_WRITE] = cmd_write && dyn_en;
  assign dly.din[LANE_CHOP]  = write_is_chop;
  assign dly.tap = term_on_latency - ONE_CYCLE;
  assign write_arrive = dly.dout[LANE_WRITE];

  // Termination switch and strength
  always_comb begin
    next_strength = term_write_strength;
    next_hold = hold_cnt;
    if (async_mode) begin
      next_term_on = term_enabled && !self_ref && termination_control_pin;
    end else begin
      next_term_on = term_enabled && !self_ref && dly.dout[LANE_PIN];
    end
    if (term_write_strength) begin
      next_hold = hold_cnt - HOLD_LAST;
      if (hold_cnt == HOLD_LAST) begin
        next_strength = 1'b0;
      end
    end
    if (write_arrive) begin
      next_strength = 1'b1;
      next_hold = dly.dout[LANE_CHOP] ? HOLD_CHOP : HOLD_FULL;
    end
    if (!dyn_en) begin
      next_strength = 1'b0;
    end
    next_code = next_strength ? {1'b0, wr_value} : nom_value;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      term_on             <= 1'b0;
      term_write_strength <= 1'b0;
      hold_cnt            <= '0;
      term_code           <= '0;
      term_dq             <= '0;
      term_dqs            <= '0;
      term_dqs_n          <= '0;
      data_mask_term      <= '0;
    end else begin
      term_on             <= next_term_on;
      term_write_strength <= next_strength;
      hold_cnt            <= next_hold;
      term_code           <= next_code;
      term_dq             <= {DQ_WIDTH{next_term_on}};
      term_dqs            <= {STROBE_GROUPS{next_term_on}};
      term_dqs_n          <= {STROBE_GROUPS{next_term_on}};
      data_mask_term      <= {STROBE_GROUPS{next_term_on}};
    end
  end

  // Avalon slave: one wait cycle, then answer for one cycle
  always_comb begin
    next_mr0 = mode_register_zero;
    next_mr1 = mode_register_one;
    next_mr2 = mode_register_two;
    next_ctrl = ctrl;
    next_readdata = avs_readdata;
    next_waitrequest = 1'b1;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = '0;
      if (avs_read) begin
        unique case (avs_address)
          OFS_MODE_ZERO: next_readdata = DATA_W'(mode_register_zero);
          OFS_MODE_ONE:  next_readdata = DATA_W'(mode_register_one);
          OFS_MODE_TWO:  next_readdata = DATA_W'(mode_register_two);
          OFS_CONTROL:   next_readdata = DATA_W'(ctrl);
          OFS_STATUS: begin
            next_readdata[ST_TERM_ON] = term_on;
            next_readdata[ST_WR_STR] = term_write_strength;
            next_readdata[ST_DYN_EN] = dyn_en;
            next_readdata[ST_ASYNC] = async_mode;
            next_readdata[ST_CODE_LSB+FLD_W-1:ST_CODE_LSB] = term_code;
          end
          default:       next_readdata = '0;
        endcase
      end
    end
    if (avs_write && !avs_waitrequest) begin
      unique case (avs_address)
        OFS_MODE_ZERO: next_mr0 = merge(mode_register_zero, avs_writedata, avs_byteenable);
        OFS_MODE_ONE:  next_mr1 = merge(mode_register_one, avs_writedata, avs_byteenable);
        OFS_MODE_TWO:  next_mr2 = merge(mode_register_two, avs_writedata, avs_byteenable);
        OFS_CONTROL: begin
          if (avs_byteenable[0]) begin
            next_ctrl = avs_writedata[CTRL_W-1:0];
          end
        end
        default:       next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_register_zero <= MR_RESET;
      mode_register_one  <= MR_RESET;
      mode_register_two  <= MR_RESET;
      ctrl               <= CTRL_RESET;
      avs_readdata       <= '0;
      avs_waitrequest    <= 1'b1;
    end else begin
      mode_register_zero <= next_mr0;
      mode_register_one  <= next_mr1;
      mode_register_two  <= next_mr2;
      ctrl               <= next_ctrl;
      avs_readdata       <= next_readdata;
      avs_waitrequest    <= next_waitrequest;
    end
  end

  // Checks
  a_selfref_off: assert property (@(posedge clock) disable iff (!rst_n)
    self_ref |=> !term_on && (term_dq == '0))
    else $error("termination on during self-refresh");

  a_disabled_off: assert property (@(posedge clock) disable iff (!rst_n)
    !term_enabled |=> !term_on && (data_mask_term == '0))
    else $error("termination on while disabled by mode registers");

  a_sync_latency: assert property (@(posedge clock) disable iff (!rst_n)
    !async_mode && term_enabled && !self_ref && term_on_latency == LAT_MIN
      && $stable(term_on_latency) && $stable(self_ref)
      |=> term_on == $past(termination_control_pin, 4))
    else $error("termination not following pin after latency");

  a_async_direct: assert property (@(posedge clock) disable iff (!rst_n)
    async_mode && term_enabled && !self_ref |=> term_on == $past(termination_control_pin))
    else $error("asynchronous termination delayed");

  a_write_strength: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_write && dyn_en && term_on_latency == LAT_MIN && $stable(term_on_latency)
      |-> ##4 (term_write_strength || !dyn_en))
    else $error("write strength not selected at latency");

  a_strength_hold: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(term_write_strength) |-> (term_write_strength || !dyn_en)[*4])
    else $error("write strength dropped early");

  a_strength_end: assert property (@(posedge clock) disable iff (!rst_n)
    term_write_strength && hold_cnt == HOLD_LAST && !write_arrive |=> !term_write_strength)
    else $error("write strength held too long");

  a_pin_low_off: assert property (@(posedge clock) disable iff (!rst_n)
    (!termination_control_pin && !async_mode && term_on_latency == LAT_MIN)[*5]
      |=> !term_on)
    else $error("termination on without pin");

  a_dyn_nominal: assert property (@(posedge clock) disable iff (!rst_n)
    !dyn_en |=> !term_write_strength && term_code == $past(nom_value))
    else $error("nominal strength not selected");

  a_reset_state: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> !term_on && !term_write_strength && avs_waitrequest)
    else $error("state not cleared by reset");

endmodule

// [dtc_ctrl_model.sv]
// Purpose: Memory controller model driving termination pin and write commands
// Assumes: Everything changes just after a rising clock edge
// Notes:   Pulses are stretched to the minimum high times the controller owes
module dtc_ctrl_model (
  input  wire logic clock,
  output logic      termination_control_pin,
  output logic      cmd_write,
  output logic      cmd_burst_full
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pin idles low, so termination stays off outside pulses and around reads
  initial begin
    termination_control_pin = 1'b0;
    cmd_write = 1'b0;
    cmd_burst_full = 1'b0;
  end

  // Pin high for hold cycles (0 keeps it low), write at offset wr_at (-1 none)
  task automatic burst(input int hold, input int wr_at, input logic full);
    int span;
    if (hold > 0 && hold < 4) hold = 4;
    if (hold > 0 && wr_at >= 0 && hold < wr_at + (full ? 6 : 4)) begin
      hold = wr_at + (full ? 6 : 4);
    end
    span = (hold > wr_at + 1) ? hold : wr_at + 1;
    for (int i = 0; i < span; i++) begin
      @(posedge clock);
      termination_control_pin <= (i < hold);
      cmd_write <= (i == wr_at);
      cmd_burst_full <= full;
    end
    @(posedge clock);
    termination_control_pin <= 1'b0;
    cmd_write <= 1'b0;
  endtask
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for the termination control block
// Assumes: One wait cycle per bus access; pin and writes come from the model
// Notes:   Expected line states come from a history of sampled pin and writes
module tb_top
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clock = 1'b0;
  logic              rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              pin;
  logic              cmd_write;
  logic              cmd_burst_full;
  logic [15:0]       term_dq;
  logic [1:0]        term_dqs;
  logic [1:0]        term_dqs_n;
  logic [1:0]        data_mask_term;
  logic              term_write_strength;
  logic [FLD_W-1:0]  term_code;
  logic [15:0]       mr0;
  logic [15:0]       mr1;
  logic [15:0]       mr2;
  logic [2:0]        ctl;
  bit   [39:0]       ph;
  bit   [39:0]       wh;
  bit   [39:0]       fh;
  bit                watch;
  int                errors;
  int                check_count;

  always #10 clock = ~clock;

  dtc_termination_ctrl u_dtc_termination_ctrl (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .termination_control_pin(pin), .cmd_write(cmd_write), .cmd_burst_full(cmd_burst_full),
    .term_dq(term_dq), .term_dqs(term_dqs), .term_dqs_n(term_dqs_n),
    .data_mask_term(data_mask_term), .term_write_strength(term_write_strength),
    .term_code(term_code));

  dtc_ctrl_model u_dtc_ctrl_model (
    .clock(clock), .termination_control_pin(pin), .cmd_write(cmd_write),
    .cmd_burst_full(cmd_burst_full));

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string n, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, q, e);
  endtask

  task automatic cfg(input logic [15:0] m0, m1, m2, input logic [2:0] c);
    idle(40);
    watch = 1'b0;
    wr(OFS_MODE_ZERO, {16'h0, m0});
    wr(OFS_MODE_ONE, {16'h0, m1});
    wr(OFS_MODE_TWO, {16'h0, m2});
    wr(OFS_CONTROL, {29'h0, c});
    mr0 = m0;
    mr1 = m1;
    mr2 = m2;
    ctl = c;
    idle(3);
    watch = 1'b1;
  endtask

  function automatic int lat();
    int cl;
    int al;
    cl = {mr0[2], mr0[6:4]} + 4;
    al = (mr1[4:3] == 2'h1) ? cl - 1 : (mr1[4:3] == 2'h2) ? cl - 2 : 0;
    return mr2[5:3] + 5 + al - 2;
  endfunction

  // Sampled pin and recorded writes, newest in bit 0
  always @(posedge clock) begin
    if (!rst_n) begin
      ph = '0;
      wh = '0;
      fh = '0;
    end else begin
      ph = {ph[38:0], pin & !ctl[0]};
      wh = {wh[38:0], cmd_write & (mr2[10:9] != 2'h0)};
      fh = {fh[38:0], (mr0[1:0] == BL_FIXED_FULL) | (mr0[1:0] == BL_OTF & cmd_burst_full)};
    end
  end

  always @(negedge clock) begin
    int   l;
    logic e;
    logic s;
    if (watch) begin
      l = lat();
      e = (ctl[1] & !mr0[12]) ? ph[0] : ph[l];
      e = e & (|{mr1[9], mr1[6], mr1[2], mr2[10:9]});
      s = 1'b0;
      for (int j = 0; j < 39; j++) if (wh[j] && j >= l && j < l + (fh[j] ? 6 : 4)) s = 1'b1;
      s = s & (|mr2[10:9]);
      chk("lines", {term_dq, term_dqs, term_dqs_n, data_mask_term}, {22{e}});
      chk("strength", term_write_strength, s);
      chk("code", term_code, s ? {1'b0, mr2[10:9]} : {mr1[9], mr1[6], mr1[2]});
    end
  end

  initial begin
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    {mr0, mr1, mr2, ctl} = '0;
    watch = 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    watch = 1'b1;
    for (int i = 0; i < 6; i++) rd_chk("reset reg", 5'(i * 4), 32'h0);
    wr(5'h14, 32'hffff_ffff);
    rd_chk("unmapped", 5'h14, 32'h0);
    for (int i = 0; i < 4; i++) if (i != 1) begin
      wr(5'(i * 4), 32'hffff_ffff);
      rd_chk("readback", 5'(i * 4), (i == 3) ? 32'h7 : 32'hffff);
      wr(5'(i * 4), 32'h0);
    end
    cfg({14'h0, BL_OTF}, 16'h0004, 16'h0200, 3'h0);
    u_dtc_ctrl_model.burst(4, -1, 1'b0);
    u_dtc_ctrl_model.burst(1, 0, 1'b0);
    u_dtc_ctrl_model.burst(2, 1, 1'b1);
    u_dtc_ctrl_model.burst(0, 0, 1'b1);
    u_dtc_ctrl_model.burst(0, 0, 1'b0);
    idle(20);
    fork
      u_dtc_ctrl_model.burst(20, -1, 1'b0);
      begin
        idle(6);
        rd_chk("status", OFS_STATUS, 32'h15);
      end
    join
    for (int i = 1; i < 8; i++) begin
      cfg(16'h0002, {6'h0, i[2], 2'h0, i[1], 3'h0, i[0], 2'h0}, {5'h0, i[1:0], 9'h0}, 3'h0);
      u_dtc_ctrl_model.burst(2, 0, 1'b0);
    end
    cfg(16'h0000, 16'h0000, 16'h0000, 3'h0);
    u_dtc_ctrl_model.burst(4, 0, 1'b1);
    for (int a = 0; a < 4; a++) begin
      cfg(16'h0020, {11'h0, a[1:0], 3'h4}, 16'h0610, 3'h0);
      u_dtc_ctrl_model.burst(4, 1, 1'b1);
    end
    cfg(16'h0000, 16'h0004, 16'h0000, 3'h1);
    u_dtc_ctrl_model.burst(6, -1, 1'b0);
    cfg(16'h0000, 16'h000c, 16'h0000, 3'h2);
    u_dtc_ctrl_model.burst(5, -1, 1'b0);
    rd_chk("status async", OFS_STATUS, 32'h18);
    cfg(16'h1000, 16'h000c, 16'h0000, 3'h6);
    u_dtc_ctrl_model.burst(5, -1, 1'b0);
    idle(40);
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    tally_and_finish();
  end
endmodule
